// *** sfs_dev_end.sv ***
// flash device end of the serial link: shifter, hold, erase engine
`timescale 1ns/1ps
`default_nettype none
`include "sfs_params.svh"
module sfs_dev_end import sfs_pkg::*; (
	input  wire logic        sys_clk,
	input  wire logic        srst,
	sfs_link_if.dev          link,
	input  wire logic [7:0]  mem_rdata,
	input  wire logic [15:0] prot_sectors,
	output logic      [15:0] mem_addr_q,
	output logic      [7:0]  mem_wdata_q,
	output logic             mem_we_q,
	output logic             busy_q
);
	logic [4:0]  s1_q, s2_q;
	logic        sck_prev_q, cs_prev_q;
	sfs_dev_st_t st_q, st_d;
	sfs_op_t     op_q, op_d;
	logic [7:0]  sr_q, sr_d, osr_q, osr_d, rdb_q;
	logic [2:0]  cin_q, cin_d, cout_q, cout_d;
	logic [1:0]  nab_q, nab_d;
	logic [15:0] addr_q, addr_d, er_q, er_d, erl_q, erl_d;
	logic        pend_q, pend_d, hold_q, hold_d, drv_q, drv_d;
	logic        dq1_q, dq1_d, dq0_q, dq0_d, oe1_q, oe0_q;
	logic [15:0] mem_addr_d;
	logic [7:0]  mem_wdata_d;
	logic        mem_we_d, busy_d;
	logic        sck_s, cs_s, si_s, hold_s, wp_s;
	logic        rise, fall, dual;
	logic [7:0]  byte_v, word;

	// sector lock from the protect pin and marked sectors
	function automatic logic locked(input logic [15:0] a,
		input logic [15:0] ps, input logic wp, input logic chip);
		locked = !wp && (chip ? (ps != `SFS_NO_SECTORS) : ps[a[15:12]]);
	endfunction

	// opcode to command kind
	function automatic sfs_op_t decode(input logic [7:0] b);
		if (b == `SFS_OP_READ) decode = OK_RD;
		else if (b == `SFS_OP_FREAD) decode = OK_FRD;
		else if (b == `SFS_OP_DREAD) decode = OK_DRD;
		else if (b == `SFS_OP_PROG) decode = OK_PROG;
		else if (b == `SFS_OP_PERASE) decode = OK_PER;
		else if (b == `SFS_OP_BERASE) decode = OK_BER;
		else if (b == `SFS_OP_CERASE_A || b == `SFS_OP_CERASE_B)
			decode = OK_CER;
		else decode = OK_NONE;
	endfunction

	// synchronised pins, floating protect and hold read high
	assign cs_s   = s2_q[4];
	assign sck_s  = s2_q[3];
	assign si_s   = s2_q[2];
	assign hold_s = s2_q[1];
	assign wp_s   = s2_q[0];
	// either idle polarity: only edges inside a frame count
	assign rise = sck_s && !sck_prev_q && !cs_s && !hold_q;
	assign fall = !sck_s && sck_prev_q && !cs_s && !hold_q;
	assign dual   = (op_q == OK_DRD);
	assign byte_v = {sr_q[6:0], si_s};
	assign word   = rdb_q;

	// link state, shifters and erase engine
	always_comb begin
		st_d = st_q; op_d = op_q; sr_d = sr_q; osr_d = osr_q;
		cin_d = cin_q; cout_d = cout_q; nab_d = nab_q;
		addr_d = addr_q; er_d = er_q; erl_d = erl_q;
		pend_d = pend_q; hold_d = hold_q; drv_d = drv_q;
		dq1_d = dq1_q; dq0_d = dq0_q; busy_d = busy_q;
		mem_wdata_d = mem_wdata_q; mem_we_d = 1'h0;
		// hold enters only selected with clock low
		if (cs_s || hold_s) hold_d = 1'h0;
		else if (!sck_s) hold_d = 1'h1;
		if (cs_s) begin
			st_d = DS_IDLE; drv_d = 1'h0;
			if (!cs_prev_q && pend_q && !busy_q) begin
				busy_d = 1'h1; pend_d = 1'h0;
				if (op_q == OK_PER) begin
					er_d  = {addr_q[15:8], `SFS_PAGE_FIRST};
					erl_d = {addr_q[15:8], `SFS_PAGE_LAST};
				end else if (op_q == OK_BER) begin
					er_d  = {addr_q[15:12], `SFS_BLK_FIRST};
					erl_d = {addr_q[15:12], `SFS_BLK_LAST};
				end else begin
					er_d  = `SFS_CHIP_FIRST;
					erl_d = `SFS_CHIP_LAST;
				end
			end
		end else begin
			case (st_q)
			DS_IDLE: begin
				if (cs_prev_q) begin
					st_d = DS_OPC; cin_d = 3'h0; cout_d = 3'h0;
					nab_d = 2'h0; pend_d = 1'h0;
				end
			end
			default: ;
			endcase
			if (rise && st_q != DS_READ && st_q != DS_IGN &&
				st_q != DS_IDLE) begin
				sr_d = byte_v; cin_d = cin_q + 3'h1;
				if (cin_q == `SFS_LAST_BIT) begin
					case (st_q)
					DS_OPC: begin
						op_d = decode(byte_v);
						if (busy_q || decode(byte_v) == OK_NONE)
							st_d = DS_IGN;
						else if (decode(byte_v) == OK_CER) begin
							st_d = DS_IGN;
							pend_d = !locked(addr_q, prot_sectors,
								wp_s, 1'h1);
						end else st_d = DS_ADDR;
					end
					DS_ADDR: begin
						addr_d = {addr_q[7:0], byte_v};
						nab_d = nab_q + 2'h1;
						if (nab_q == `SFS_LAST_ABYTE) begin
							if (op_q == OK_RD) st_d = DS_READ;
							else if (op_q == OK_PROG) st_d = DS_PROG;
							else if (op_q == OK_FRD || dual)
								st_d = DS_DUMMY;
							else begin
								st_d = DS_IGN;
								pend_d = !locked({addr_q[7:0], byte_v},
									prot_sectors, wp_s, 1'h0);
							end
						end
					end
					DS_DUMMY: st_d = DS_READ;
					DS_PROG: begin
						if (!locked(addr_q, prot_sectors, wp_s, 1'h0)) begin
							mem_we_d = 1'h1; mem_wdata_d = byte_v;
						end
						addr_d = {addr_q[15:8],
							addr_q[7:0] + `SFS_BYTE_ONE};
					end
					default: ;
					endcase
				end
			end
			// outgoing bits change on falling edges only
			if (fall && st_q == DS_READ) begin
				drv_d = 1'h1;
				if (cout_q == 3'h0) begin
					addr_d = addr_q + `SFS_ADDR_ONE;
					dq1_d = word[7];
					dq0_d = word[6];
					osr_d = dual ? {word[5:0], 2'h0} : {word[6:0], 1'h0};
				end else begin
					dq1_d = osr_q[7];
					dq0_d = osr_q[6];
					osr_d = dual ? {osr_q[5:0], 2'h0} : {osr_q[6:0], 1'h0};
				end
				if (dual && cout_q == `SFS_LAST_PAIR) cout_d = 3'h0;
				else cout_d = cout_q + 3'h1;
			end
		end
		// erase engine ignores hold and select entirely
		if (busy_q) begin
			mem_we_d = 1'h1;
			mem_wdata_d = `SFS_ERASED;
			er_d = er_q + `SFS_ADDR_ONE;
			if (er_q == erl_q) busy_d = 1'h0;
		end
		mem_addr_d = busy_q ? er_q : addr_q;
	end

	// state registers; hold freezes shifters in place
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s1_q <= 5'h1F; s2_q <= 5'h1F;
			sck_prev_q <= 1'h0; cs_prev_q <= 1'h1;
			st_q <= DS_IDLE; op_q <= OK_NONE;
			sr_q <= 8'h00; osr_q <= 8'h00; rdb_q <= 8'h00;
			cin_q <= 3'h0; cout_q <= 3'h0; nab_q <= 2'h0;
			addr_q <= 16'h0000; er_q <= 16'h0000; erl_q <= 16'h0000;
			pend_q <= 1'h0; hold_q <= 1'h0; drv_q <= 1'h0;
			dq1_q <= 1'h0; dq0_q <= 1'h0; oe1_q <= 1'h1; oe0_q <= 1'h1;
			mem_addr_q <= 16'h0000; mem_wdata_q <= 8'h00;
			mem_we_q <= 1'h0; busy_q <= 1'h0;
		end else begin
			s1_q <= {link.cs_n, link.sck, link.dual_lane_low,
				link.hold_n, link.wp_n};
			s2_q <= s1_q;
			sck_prev_q <= sck_s; cs_prev_q <= cs_s;
			st_q <= st_d; op_q <= op_d; sr_q <= sr_d; osr_q <= osr_d;
			rdb_q <= mem_rdata;
			cin_q <= cin_d; cout_q <= cout_d; nab_q <= nab_d;
			addr_q <= addr_d; er_q <= er_d; erl_q <= erl_d;
			pend_q <= pend_d; hold_q <= hold_d; drv_q <= drv_d;
			dq1_q <= dq1_d; dq0_q <= dq0_d;
			oe1_q <= !(drv_d && !hold_d && !cs_s);
			oe0_q <= !(drv_d && !hold_d && !cs_s && dual);
			mem_addr_q <= mem_addr_d; mem_wdata_q <= mem_wdata_d;
			mem_we_q <= mem_we_d; busy_q <= busy_d;
		end
	end

	// pin drivers, all from flops
	assign link.dev_dq1_o    = dq1_q;
	assign link.dev_dq0_o    = dq0_q;
	assign link.dev_dq1_oe_n = oe1_q;
	assign link.dev_dq0_oe_n = oe0_q;
endmodule // sfs_dev_end
`default_nettype wire

// *** sfs_host_end.sv ***
// host end of the serial link: mode 0 clock, byte shifter, hold
`timescale 1ns/1ps
`default_nettype none
`include "sfs_params.svh"
module sfs_host_end import sfs_pkg::*; (
	input  wire logic       sys_clk,
	input  wire logic       srst,
	sfs_link_if.host        link,
	input  wire logic       go,
	input  wire logic [8:0] tx_len,
	input  wire logic [8:0] rx_len,
	input  wire logic       dual,
	input  wire logic [7:0] tx_byte,
	input  wire logic       hold_req,
	input  wire logic       wp_lock,
	output logic            tx_take_q,
	output logic      [7:0] rx_byte_q,
	output logic            rx_valid_q,
	output logic            busy_q
);
	localparam logic [3:0] HALF_M1 = 4'(`SFS_SCK_HALF_CYC - 1);
	sfs_host_st_t st_q, st_d;
	logic [3:0]   div_q, div_d;
	logic [8:0]   txr_q, txr_d, rxr_q, rxr_d;
	logic [7:0]   sh_q, sh_d, rsh_q, rsh_d, rxb_d;
	logic [2:0]   bc_q, bc_d;
	logic         ld_q, ld_d, dl_q, dl_d;
	logic         cs_q, cs_d, sck_q, sck_d, si_q, si_d, sioe_q, sioe_d;
	logic         hld_q, hld_d, take_d, rxv_d, busy_d;
	logic [1:0]   p1_q, p2_q;
	logic [7:0]   nxt;
	logic         tick;

	assign tick = (div_q == HALF_M1) && !hld_q;
	assign nxt  = dl_q ? {rsh_q[5:0], p2_q} : {rsh_q[6:0], p2_q[1]};

	// transfer sequencing on the divided clock
	always_comb begin
		st_d = st_q; div_d = div_q; txr_d = txr_q; rxr_d = rxr_q;
		sh_d = sh_q; rsh_d = rsh_q; rxb_d = rx_byte_q; bc_d = bc_q;
		ld_d = ld_q; dl_d = dl_q; cs_d = cs_q; sck_d = sck_q;
		si_d = si_q; sioe_d = sioe_q; busy_d = busy_q;
		take_d = 1'h0; rxv_d = 1'h0;
		// hold only while busy with clock low and not about to rise
		if (!hold_req) hld_d = 1'h0;
		else if (st_q != HS_IDLE && !sck_q && !tick) hld_d = 1'h1;
		else hld_d = hld_q;
		if (st_q != HS_IDLE && !hld_q)
			div_d = tick ? 4'h0 : div_q + 4'h1;
		case (st_q)
		HS_IDLE: begin
			if (go) begin
				st_d = HS_TX; cs_d = 1'h0; busy_d = 1'h1;
				si_d = tx_byte[7]; sh_d = {tx_byte[6:0], 1'h0};
				sioe_d = 1'h0; take_d = 1'h1; bc_d = 3'h0;
				txr_d = tx_len - 9'h001; rxr_d = rx_len;
				dl_d = dual; ld_d = 1'h0; div_d = 4'h0;
			end
		end
		HS_TX: begin
			if (tick && !sck_q) begin
				sck_d = 1'h1; bc_d = bc_q + 3'h1;
				if (bc_q == `SFS_LAST_BIT) begin
					if (txr_q != 9'h000) begin
						txr_d = txr_q - 9'h001; ld_d = 1'h1;
					end else if (rxr_q != 9'h000) begin
						st_d = HS_RX; rxr_d = rxr_q - 9'h001;
						sioe_d = dl_q; // release the low lane for dual reads only
					end else st_d = HS_END;
				end
			end else if (tick) begin
				sck_d = 1'h0; ld_d = 1'h0;
				if (ld_q) begin
					si_d = tx_byte[7]; sh_d = {tx_byte[6:0], 1'h0};
					take_d = 1'h1;
				end else begin
					si_d = sh_q[7]; sh_d = {sh_q[6:0], 1'h0};
				end
			end
		end
		HS_RX: begin
			if (tick && !sck_q) begin
				sck_d = 1'h1; rsh_d = nxt; bc_d = bc_q + 3'h1;
				if (bc_q == (dl_q ? `SFS_LAST_PAIR : `SFS_LAST_BIT)) begin
					bc_d = 3'h0; rxb_d = nxt; rxv_d = 1'h1;
					if (rxr_q == 9'h000) st_d = HS_END;
					else rxr_d = rxr_q - 9'h001;
				end
			end else if (tick) sck_d = 1'h0;
		end
		HS_END: begin
			if (tick) begin
				if (sck_q) sck_d = 1'h0;
				else if (!cs_q) begin
					cs_d = 1'h1; sioe_d = 1'h1;
				end else begin
					st_d = HS_IDLE; busy_d = 1'h0;
				end
			end
		end
		default: st_d = HS_IDLE;
		endcase
	end

	// registers and pin inputs through two flops
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_q <= HS_IDLE; div_q <= 4'h0; txr_q <= 9'h000;
			rxr_q <= 9'h000; sh_q <= 8'h00; rsh_q <= 8'h00;
			bc_q <= 3'h0; ld_q <= 1'h0; dl_q <= 1'h0;
			cs_q <= 1'h1; sck_q <= 1'h0; si_q <= 1'h0; sioe_q <= 1'h1;
			hld_q <= 1'h0; p1_q <= 2'h3; p2_q <= 2'h3;
			tx_take_q <= 1'h0; rx_byte_q <= 8'h00;
			rx_valid_q <= 1'h0; busy_q <= 1'h0;
		end else begin
			st_q <= st_d; div_q <= div_d; txr_q <= txr_d; rxr_q <= rxr_d;
			sh_q <= sh_d; rsh_q <= rsh_d; bc_q <= bc_d;
			ld_q <= ld_d; dl_q <= dl_d;
			cs_q <= cs_d; sck_q <= sck_d; si_q <= si_d; sioe_q <= sioe_d;
			hld_q <= hld_d;
			p1_q <= {link.dual_lane_high, link.dual_lane_low};
			p2_q <= p1_q;
			tx_take_q <= take_d; rx_byte_q <= rxb_d;
			rx_valid_q <= rxv_d; busy_q <= busy_d;
		end
	end

	// the four link signals plus hold and protect
	assign link.cs_n         = cs_q;
	assign link.sck          = sck_q;
	assign link.host_si_o    = si_q;
	assign link.host_si_oe_n = sioe_q;
	assign link.hold_oe_n    = !hld_q;
	assign link.wp_oe_n      = !wp_lock;
endmodule // sfs_host_end
`default_nettype wire

// *** sfs_link_if.sv ***
// serial flash link pins with pull-ups on the shared lines
`timescale 1ns/1ps
`default_nettype none
interface sfs_link_if;
	logic cs_n;
	logic sck;
	logic host_si_o;
	logic host_si_oe_n;
	logic hold_oe_n;
	logic wp_oe_n;
	logic dev_dq0_o;
	logic dev_dq0_oe_n;
	logic dev_dq1_o;
	logic dev_dq1_oe_n;
	logic dual_lane_low;
	logic dual_lane_high;
	logic hold_n;
	logic wp_n;
	// line resolution, undriven lines float high
	assign dual_lane_low  = !dev_dq0_oe_n ? dev_dq0_o :
		(!host_si_oe_n ? host_si_o : 1'h1);
	assign dual_lane_high = !dev_dq1_oe_n ? dev_dq1_o : 1'h1;
	assign hold_n = hold_oe_n ? 1'h1 : 1'h0;
	assign wp_n   = wp_oe_n ? 1'h1 : 1'h0;
	modport dev (input cs_n, sck, dual_lane_low, hold_n, wp_n,
		output dev_dq0_o, dev_dq0_oe_n, dev_dq1_o, dev_dq1_oe_n);
	modport host (output cs_n, sck, host_si_o, host_si_oe_n, hold_oe_n,
		wp_oe_n, input dual_lane_low, dual_lane_high);
endinterface
`default_nettype wire

// *** sfs_link_sva.sv ***
// pin-level checker for the serial flash link between both ends
`timescale 1ns/1ps
`default_nettype none
module sfs_link_chk (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic hold_n,
	input wire logic dev_dq0_oe_n,
	input wire logic dev_dq1_oe_n,
	input wire logic dual_lane_high
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	// settled deselect and settled hold, long enough to pass the syncs
	sequence s_desel;
		cs_n [*5];
	endsequence
	sequence s_held;
		(!hold_n && !cs_n && !sck) [*6];
	endsequence
	// lane enables and link clock timing
	chk_desel_release: assert property (s_desel |-> dev_dq0_oe_n && dev_dq1_oe_n)
		else $error("device drives a lane while deselected");
	chk_hold_release: assert property (s_held |-> dev_dq0_oe_n && dev_dq1_oe_n)
		else $error("device drives a lane during hold");
	chk_hold_start: assert property ($fell(hold_n) |-> !cs_n && !sck)
		else $error("hold began outside a frame or with clock high");
	chk_idle_low: assert property (cs_n |-> !sck)
		else $error("link clock high while idle");
	chk_sck_framed: assert property ($changed(sck) |-> !cs_n)
		else $error("link clock moved outside a frame");
	chk_half_period: assert property ($changed(sck) |=> $stable(sck) [*7])
		else $error("link clock half period too short");
	chk_out_falling: assert property (!dev_dq1_oe_n && !$past(dev_dq1_oe_n)
		&& $changed(dual_lane_high) |-> !sck)
		else $error("output lane changed with clock high");
	chk_stable_rise: assert property ($rose(sck) && !dev_dq1_oe_n
		|-> $stable(dual_lane_high))
		else $error("output lane moved at a rising edge");
	chk_oe_start: assert property ($fell(dev_dq1_oe_n)
		|-> !cs_n && hold_n && !sck)
		else $error("output enabled while not selected or held");
	chk_dual_pair: assert property (!dev_dq0_oe_n |-> !dev_dq1_oe_n)
		else $error("low lane driven without high lane");
endmodule // sfs_link_chk
`default_nettype wire

// *** sfs_params.svh ***
// timing, opcode and field constants for the serial flash link
`ifndef SFS_PARAMS_SVH
`define SFS_PARAMS_SVH
`define SFS_CLK_NS       10
`define SFS_SCK_HALF_NS  80
`define SFS_SCK_HALF_CYC (`SFS_SCK_HALF_NS / `SFS_CLK_NS)
`define SFS_OP_READ      8'h03
`define SFS_OP_FREAD     8'h0B
`define SFS_OP_DREAD     8'h3B
`define SFS_OP_PROG      8'h02
`define SFS_OP_PERASE    8'h81
`define SFS_OP_BERASE    8'h20
`define SFS_OP_CERASE_A  8'h60
`define SFS_OP_CERASE_B  8'hC7
`define SFS_ERASED       8'hFF
`define SFS_LAST_BIT     3'h7
`define SFS_LAST_PAIR    3'h3
`define SFS_LAST_ABYTE   2'h2
`define SFS_ADDR_ONE     16'h0001
`define SFS_BYTE_ONE     8'h01
`define SFS_CHIP_FIRST   16'h0000
`define SFS_CHIP_LAST    16'hFFFF
`define SFS_PAGE_FIRST   8'h00
`define SFS_PAGE_LAST    8'hFF
`define SFS_BLK_FIRST    12'h000
`define SFS_BLK_LAST     12'hFFF
`define SFS_NO_SECTORS   16'h0000
`endif

// *** sfs_pkg.sv ***
// state and command types shared by both link ends
package sfs_pkg;
	typedef enum logic [6:0] {
		DS_IDLE  = 7'h01,
		DS_OPC   = 7'h02,
		DS_ADDR  = 7'h04,
		DS_DUMMY = 7'h08,
		DS_READ  = 7'h10,
		DS_PROG  = 7'h20,
		DS_IGN   = 7'h40
	} sfs_dev_st_t;
	typedef enum logic [3:0] {
		HS_IDLE = 4'h1,
		HS_TX   = 4'h2,
		HS_RX   = 4'h4,
		HS_END  = 4'h8
	} sfs_host_st_t;
	typedef enum logic [2:0] {
		OK_NONE, OK_RD, OK_FRD, OK_DRD, OK_PROG, OK_PER, OK_BER, OK_CER
	} sfs_op_t;
endpackage

// *** tb_top.sv ***
// bench: host and device ends joined, user sides driven and judged
`timescale 1ns/1ps
`default_nettype none
`include "sfs_params.svh"
module tb_top;
	logic        sys_clk;
	logic        srst;
	logic        go;
	logic [8:0]  tx_len;
	logic [8:0]  rx_len;
	logic        dual;
	logic        hold_req;
	logic        wp_lock;
	logic [15:0] prot_sectors;
	logic [7:0]  tx_byte;
	logic        tx_take_q;
	logic [7:0]  rx_byte_q;
	logic        rx_valid_q;
	logic        hbusy;
	logic        dbusy;
	logic [15:0] mem_addr_q;
	logic [7:0]  mem_wdata_q;
	logic        mem_we_q;
	logic [7:0]  mem_rdata;
	logic [7:0]  mem [0:65535];
	logic [7:0]  txb [0:7];
	logic [7:0]  rxb [0:3];
	logic [2:0]  tx_idx;
	logic [1:0]  rx_idx;
	int          fail_count;
	int          checks_done;
	sfs_link_if link_if ();
	sfs_host_end sfs_host_end_i (.sys_clk, .srst, .link(link_if), .go,
		.tx_len, .rx_len, .dual, .tx_byte, .hold_req, .wp_lock, .tx_take_q,
		.rx_byte_q, .rx_valid_q, .busy_q(hbusy));
	sfs_dev_end sfs_dev_end_i (.sys_clk, .srst, .link(link_if), .mem_rdata,
		.prot_sectors, .mem_addr_q, .mem_wdata_q, .mem_we_q, .busy_q(dbusy));
	sfs_link_chk sfs_link_chk_i (.sys_clk, .srst, .cs_n(link_if.cs_n),
		.sck(link_if.sck), .hold_n(link_if.hold_n),
		.dev_dq0_oe_n(link_if.dev_dq0_oe_n),
		.dev_dq1_oe_n(link_if.dev_dq1_oe_n),
		.dual_lane_high(link_if.dual_lane_high));
	// clock and array read port
	always #5 sys_clk = ~sys_clk;
	assign mem_rdata = mem[mem_addr_q];
	assign tx_byte = txb[tx_idx];
	// array writes, send index and receive capture
	always @(posedge sys_clk) begin
		if (mem_we_q) mem[mem_addr_q] <= mem_wdata_q;
		// indices rest at zero while the host is idle
		if (!hbusy) tx_idx <= 3'h0;
		else if (tx_take_q) tx_idx <= tx_idx + 3'h1;
		if (!hbusy) rx_idx <= 2'h0;
		else if (rx_valid_q) begin
			rxb[rx_idx] <= rx_byte_q;
			rx_idx <= rx_idx + 2'h1;
		end
	end
	function automatic logic [7:0] ini(input logic [15:0] a);
		return a[7:0] ^ a[15:8];
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			fail_count++;
		end
	endtask
	task automatic cmd(input logic [7:0] op, input logic [15:0] a);
		txb[0] = op;
		txb[1] = 8'h00;
		txb[2] = a[15:8];
		txb[3] = a[7:0];
		txb[4] = 8'h00;
	endtask
	// one frame, then wait for the host and any erase to finish
	task automatic xfer(input logic [8:0] nt, input logic [8:0] nr,
		input logic dl);
		int n;
		@(posedge sys_clk);
		#1;
		go = 1'h1;
		tx_len = nt;
		rx_len = nr;
		dual = dl;
		@(posedge sys_clk);
		#1;
		go = 1'h0;
		n = 0;
		while ((hbusy === 1'h1 || n < 2) && n < 4000) begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= 4000) begin
			$display("unexpected at %0t: host busy %h expected %h",
				$time, hbusy, 1'h0);
			fail_count++;
		end
		repeat (4) @(posedge sys_clk);
		n = 0;
		while (dbusy === 1'h1 && n < 70000) begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= 70000) begin
			$display("unexpected at %0t: device busy %h expected %h",
				$time, dbusy, 1'h0);
			fail_count++;
		end
		#1;
	endtask
	task automatic t_program;
		cmd(`SFS_OP_PROG, 16'h12FF);
		txb[4] = 8'hA5;
		txb[5] = 8'h3C;
		xfer(9'h6, 9'h0, 1'h0);
		chk(mem[16'h12FF], 8'hA5);
		chk(mem[16'h1200], 8'h3C);
		chk(mem[16'h1300], ini(16'h1300));
	endtask
	task automatic t_reads;
		logic [7:0] ops [0:2] = '{`SFS_OP_READ, `SFS_OP_FREAD, `SFS_OP_DREAD};
		for (int i = 0; i < 3; i++) begin
			cmd(ops[i], 16'h12FF);
			xfer((i == 0) ? 9'h4 : 9'h5, 9'h2, i == 2);
			chk(rxb[0], 8'hA5);
			chk(rxb[1], ini(16'h1300));
		end
	endtask
	// hold once in the address phase, once in the data phase
	task automatic t_hold;
		cmd(`SFS_OP_READ, 16'h1200);
		fork
			xfer(9'h4, 9'h1, 1'h0);
			// second wait longer so the pause lands in the data byte
			for (int k = 0; k < 2; k++) begin
				repeat (250 + 80 * k) @(posedge sys_clk);
				#1;
				hold_req = 1'h1;
				repeat (80) @(posedge sys_clk);
				#1;
				hold_req = 1'h0;
			end
		join
		chk(rxb[0], 8'h3C);
	endtask
	task automatic t_erase;
		wp_lock = 1'h1;
		prot_sectors = 16'h0002;
		cmd(`SFS_OP_PERASE, 16'h1200);
		xfer(9'h4, 9'h0, 1'h0);
		chk(mem[16'h1200], 8'h3C);
		cmd(`SFS_OP_CERASE_A, 16'h0000);
		xfer(9'h4, 9'h0, 1'h0);
		chk(mem[16'h0000], ini(16'h0000));
		wp_lock = 1'h0;
		cmd(`SFS_OP_PERASE, 16'h1200);
		xfer(9'h4, 9'h0, 1'h0);
		chk(mem[16'h12FF], `SFS_ERASED);
		chk(mem[16'h1300], ini(16'h1300));
		cmd(`SFS_OP_BERASE, 16'h2345);
		xfer(9'h4, 9'h0, 1'h0);
		chk(mem[16'h2FFF], `SFS_ERASED);
		chk(mem[16'h3000], ini(16'h3000));
		cmd(`SFS_OP_CERASE_B, 16'h0000);
		xfer(9'h4, 9'h0, 1'h0);
		chk(mem[16'hFFFF], `SFS_ERASED);
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		sys_clk = 1'h0;
		srst = 1'h1;
		go = 1'h0;
		tx_len = 9'h0;
		rx_len = 9'h0;
		dual = 1'h0;
		hold_req = 1'h0;
		wp_lock = 1'h0;
		prot_sectors = 16'h0000;
		fail_count = 0;
		checks_done = 0;
		txb = '{default: 8'h00};
		for (int i = 0; i < 65536; i++) mem[i] = ini(i[15:0]);
		repeat (3) @(posedge sys_clk);
		#1;
		srst = 1'h0;
		repeat (3) @(posedge sys_clk);
		t_program();
		t_reads();
		t_hold();
		t_erase();
		final_report();
	end
	// watchdog against a hung handshake
	initial begin
		#950000;
		fail_count++;
		final_report();
	end
endmodule // tb_top
`default_nettype wire
